// ===== arc_cfg.svh
// register map, field positions, reset values and timing counts of the arc block
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH
`define CLK_MHZ 100
`define CYCLE_MS 5
`define CYCLE_CLKS (`CYCLE_MS * 1000 * `CLK_MHZ)
`define MS_CLKS (1000 * `CLK_MHZ)
`define TP_US 20
`define TP_CLKS (`TP_US * `CLK_MHZ)
`define LOG_DEPTH 12
`define A_CTRL 8'h00
`define A_ZLIGHT 8'h04
`define A_ZCURR 8'h08
`define A_SCFG 8'h0C
`define A_DLY 8'h10
`define A_PKP 8'h14
`define A_STAT 8'h18
`define A_CNT_ST 8'h1C
`define A_CNT_BK 8'h20
`define A_TIME 8'h24
`define A_LSEL 8'h28
`define A_LTIME 8'h2C
`define A_LINFO 8'h30
`define A_LMAG 8'h34
`define A_LREM 8'h38
`define A_LCNT 8'h3C
`define CTRL_TPI 4
`define CTRL_MON 5
`define CTRL_MOFF 6
`define CTRL_CLR 8
`define CTRL_RST 32'h0000_0020
`define ZL_RST 32'h0000_0000
`define ZC_RST 32'h0000_0000
`define SCFG_RST 32'h0000_0000
`define DLY_RST 32'h000C_0000
`define PKP_RST 32'h0100_0100
`endif

// ===== arc_pkg.sv
// shared types of the arc protection block
package arc_pkg;
  typedef enum logic {SCAN_IDLE, SCAN_RUN} scan_state_t;
  typedef logic [15:0] mag_t;
  typedef logic [2:0] stage_idx_t;
  typedef logic [1:0] kind_idx_t;
endpackage : arc_pkg

// ===== sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule : sync2
`default_nettype wire

// ===== event_stage.sv
// one pick-up stage: start, trip and blocked flags with operate and release timing
`timescale 1ns/1ns
`default_nettype none
module event_stage (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic pickup,
  input wire logic block,
  input wire logic [15:0] op_dly,
  input wire logic [15:0] rel_dly,
  output logic start_ff,
  output logic trip_ff,
  output logic blocked_ff,
  output logic [15:0] remain
);
  logic [15:0] op_ff;
  logic [15:0] rel_ff;
  wire logic go = pickup & ~block;
  wire logic at_lim = op_ff >= op_dly;
  // the operate count is held through the tick that drops start, then for the release ticks
  wire logic [15:0] nxt_op = go ? (at_lim ? op_ff : op_ff + 16'h0001) : ((rel_ff == 16'h0000 && !start_ff) ? 16'h0000 : op_ff);
  // a start dropped by blocking runs the same release as a lost pick-up
  wire logic [15:0] nxt_rel = go ? 16'h0000 : (start_ff ? rel_dly : ((rel_ff == 16'h0000) ? rel_ff : rel_ff - 16'h0001));
  assign remain = at_lim ? 16'h0000 : op_dly - op_ff;
  // flags move only on the cycle tick, with block sampled there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_ff <= 1'b0;
      trip_ff <= 1'b0;
      blocked_ff <= 1'b0;
      op_ff <= 16'h0000;
      rel_ff <= 16'h0000;
    end else if (tick) begin
      start_ff <= go;
      trip_ff <= go & at_lim;
      blocked_ff <= pickup & block;
      op_ff <= nxt_op;
      rel_ff <= nxt_rel;
    end
  end
  property p_block_stops;
    @(posedge pclk) disable iff (!presetn) (tick && pickup && block) |=> (blocked_ff && !start_ff && !trip_ff);
  endproperty
  a_block_stops: assert property (p_block_stops) else $error("blocked pick-up still starts or trips");
  property p_start_go;
    @(posedge pclk) disable iff (!presetn) (tick && pickup && !block) |=> (start_ff && !blocked_ff);
  endproperty
  a_start_go: assert property (p_start_go) else $error("unblocked pick-up gave no start");
  property p_only_tick;
    @(posedge pclk) disable iff (!presetn) !$stable({start_ff, trip_ff, blocked_ff}) |-> $past(tick);
  endproperty
  a_only_tick: assert property (p_only_tick) else $error("flag moved between cycle ticks");
  property p_rel_load;
    @(posedge pclk) disable iff (!presetn) (tick && start_ff && block) |=> (rel_ff == $past(rel_dly));
  endproperty
  a_rel_load: assert property (p_rel_load) else $error("blocking did not start release timing");
endmodule : event_stage
`default_nettype wire

// ===== arc_fault_zone_protection.sv
// arc fault zone protection with apb registers, event scanner, counters and operation log
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "arc_cfg.svh"
// How it works
// - four sensor channels, each carrying up to three point sensors.
// - each channel's light flag drives its own light output.
// - each channel's pressure flag drives its own pressure output.
// - arc binary input output follows the energized card input.
// - phase and residual current start flags when current exceeds limit.
// - phase and residual blocked flags when their block input is active while current exceeds limit.
// - zone trips on enabled light, plus enabled current conditions.
// - zone conditions met while blocked give zone blocked, not trip.
// - channel sensor fault when detected count differs from configured count.
// - unit fault when connected unit count differs from configured count.
// - enabled current in zone needs light and current above limit.
// - pressure enabled per zone and channel like light.
// - with test pulse option, short wiring pulses never raise the binary input.
// - blocking input sampled at the start of each program cycle.
// - unblocked pick-up gives start and runs operate timing.
// - blocked pick-up gives blocked and nothing more.
// - start cut by blocking clears and runs release timing.
// - events on on and off edges, stored per on/off selection.
// - cumulative start, trip, blocked counters, software resettable.
// - last twelve on-event records kept with process data.
// - record holds time in ms, event, magnitude, ratio, remaining time, group.
// - each zone has its own enable; disabled zone never trips.
// - configured sensors per channel is zero to three, fault reference.
module arc_fault_zone_protection #(
  parameter int unsigned CYCLE_CLKS = `CYCLE_CLKS,
  parameter int unsigned MS_CLKS = `MS_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] light_raw,
  input wire logic [3:0] pressure_raw,
  input wire logic arc_card_binary_input,
  input wire logic [7:0] sens_det_raw,
  input wire logic [3:0] unit_det_raw,
  input wire logic phase_over,
  input wire logic residual_over,
  input wire logic phase_block,
  input wire logic residual_block,
  input wire logic [3:0] zone_block,
  input wire logic [15:0] phase_mag,
  input wire logic [15:0] residual_mag,
  output logic [3:0] light_out,
  output logic [3:0] pressure_out,
  output logic arc_bi_out,
  output logic phase_start,
  output logic residual_start,
  output logic phase_blocked,
  output logic residual_blocked,
  output logic [3:0] zone_trip,
  output logic [3:0] zone_blocked,
  output logic [3:0] sensor_fault,
  output logic unit_fault,
  output logic ev_valid,
  output logic [5:0] ev_code,
  output logic [31:0] ev_time
);
  localparam logic [10:0] TP_MAX = 11'(`TP_CLKS);
  wire logic [20:0] sync_q;
  sync2 #(.W(21)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({unit_det_raw, sens_det_raw, arc_card_binary_input, pressure_raw, light_raw}),
    .q(sync_q)
  );
  wire logic [3:0] light_s = sync_q[3:0];
  wire logic [3:0] press_s = sync_q[7:4];
  wire logic bi_s = sync_q[8];
  wire logic [7:0] det_s = sync_q[16:9];
  wire logic [3:0] unit_s = sync_q[20:17];

  logic [31:0] ctrl_ff, zl_ff, zc_ff, scfg_ff, dly_ff, pkp_ff, time_ff;
  logic [3:0] lsel_ff;
  logic [3:0] lit_ff, prs_ff, sf_ff;
  logic bi_ff, uf_ff;
  logic [10:0] tp_ff;
  logic [19:0] cyc_ff;
  logic [16:0] ms_ff;
  logic tick, tick_d_ff;
  logic [31:0] prdata_ff, rd_data;
  logic pready_ff, pslverr_ff;

  // apb decode: zero-wait answer one cycle after setup
  wire logic setup = psel & ~penable;
  wire logic wr_en = psel & penable & pready_ff & pwrite;
  wire logic hit = (paddr[1:0] == 2'h0) & (paddr <= `A_LCNT);
  wire logic cnt_clr = wr_en & (paddr == `A_CTRL) & pwdata[`CTRL_CLR];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RST;
      zl_ff <= `ZL_RST;
      zc_ff <= `ZC_RST;
      scfg_ff <= `SCFG_RST;
      dly_ff <= `DLY_RST;
      pkp_ff <= `PKP_RST;
      lsel_ff <= 4'h0;
    end else if (wr_en) begin
      case (paddr)
        `A_CTRL: ctrl_ff <= pwdata & 32'h0000_007F;
        `A_ZLIGHT: zl_ff <= pwdata;
        `A_ZCURR: zc_ff <= pwdata & 32'h0000_00FF;
        `A_SCFG: scfg_ff <= pwdata & 32'h0000_7FFF;
        `A_DLY: dly_ff <= pwdata;
        `A_PKP: pkp_ff <= pwdata;
        `A_LSEL: lsel_ff <= (pwdata[3:0] > 4'hB) ? 4'hB : pwdata[3:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit;
      prdata_ff <= (setup & ~pwrite & hit) ? rd_data : 32'h0000_0000;
    end
  end

  // program cycle tick and millisecond time base
  assign tick = cyc_ff == 20'(CYCLE_CLKS - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= 20'h00000;
      ms_ff <= 17'h00000;
      time_ff <= 32'h0000_0000;
      tick_d_ff <= 1'b0;
    end else begin
      cyc_ff <= tick ? 20'h00000 : cyc_ff + 20'h00001;
      tick_d_ff <= tick;
      ms_ff <= (ms_ff == 17'(MS_CLKS - 1)) ? 17'h00000 : ms_ff + 17'h00001;
      if (wr_en && paddr == `A_TIME) begin
        time_ff <= pwdata;
      end else if (ms_ff == 17'(MS_CLKS - 1)) begin
        time_ff <= time_ff + 32'h0000_0001;
      end
    end
  end

  // sensor levels, binary input filter and configuration supervision
  wire logic [3:0] sf_now;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lit_ff <= 4'h0;
      prs_ff <= 4'h0;
      bi_ff <= 1'b0;
      tp_ff <= 11'h000;
      sf_ff <= 4'h0;
      uf_ff <= 1'b0;
    end else begin
      lit_ff <= light_s;
      prs_ff <= press_s;
      tp_ff <= bi_s ? ((tp_ff == TP_MAX) ? tp_ff : tp_ff + 11'h001) : 11'h000;
      bi_ff <= ctrl_ff[`CTRL_TPI] ? (bi_s & (tp_ff == TP_MAX)) : bi_s;
      sf_ff <= sf_now;
      uf_ff <= unit_s != scfg_ff[11:8];
    end
  end

  // six stages: zones 0..3, phase current 4, residual current 5
  wire logic [5:0] pick_v, blk_in_v;
  wire logic [5:0] start_v, trip_v, blk_v;
  wire logic [15:0] remain_v [6];
  wire logic [3:0] zone_pick;
  wire logic ph_ok = phase_over & ~phase_block;
  wire logic re_ok = residual_over & ~residual_block;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_zone
      assign sf_now[g] = det_s[2*g +: 2] != scfg_ff[2*g +: 2];
      assign zone_pick[g] = ctrl_ff[g]
        & (|(lit_ff & zl_ff[4*g +: 4]) | |(prs_ff & zl_ff[16+4*g +: 4]))
        & (~zc_ff[g] | ph_ok) & (~zc_ff[4+g] | re_ok);
    end
    for (g = 0; g < 6; g++) begin : g_stage
      event_stage u_stage (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .pickup(pick_v[g]),
        .block(blk_in_v[g]),
        .op_dly((g < 4) ? dly_ff[15:0] : 16'h0000),
        .rel_dly(dly_ff[31:16]),
        .start_ff(start_v[g]),
        .trip_ff(trip_v[g]),
        .blocked_ff(blk_v[g]),
        .remain(remain_v[g])
      );
    end
  endgenerate
  assign pick_v = {residual_over, phase_over, zone_pick};
  assign blk_in_v = {residual_block, phase_block, zone_block};

  // scanner: after each tick walks all 18 flags, one change per cycle
  arc_pkg::scan_state_t st_ff;
  arc_pkg::stage_idx_t sidx_ff;
  arc_pkg::kind_idx_t kidx_ff;
  logic [5:0] pv_st_ff, pv_tr_ff, pv_bk_ff;
  logic ev_valid_ff;
  logic [5:0] ev_code_ff;
  logic [31:0] ev_time_ff;
  logic [15:0] cnt_st_ff, cnt_tr_ff, cnt_bk_ff;
  wire logic cur_bit = (kidx_ff == 2'h0) ? start_v[sidx_ff] : (kidx_ff == 2'h1) ? trip_v[sidx_ff] : blk_v[sidx_ff];
  wire logic prv_bit = (kidx_ff == 2'h0) ? pv_st_ff[sidx_ff] : (kidx_ff == 2'h1) ? pv_tr_ff[sidx_ff] : pv_bk_ff[sidx_ff];
  wire logic chg = (st_ff == arc_pkg::SCAN_RUN) & (cur_bit != prv_bit);
  wire logic on_ev = chg & cur_bit;
  wire logic last = (kidx_ff == 2'h2) & (sidx_ff == 3'h5);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= arc_pkg::SCAN_IDLE;
      sidx_ff <= 3'h0;
      kidx_ff <= 2'h0;
    end else begin
      case (st_ff)
        arc_pkg::SCAN_IDLE: begin
          sidx_ff <= 3'h0;
          kidx_ff <= 2'h0;
          if (tick_d_ff) begin
            st_ff <= arc_pkg::SCAN_RUN;
          end
        end
        arc_pkg::SCAN_RUN: begin
          kidx_ff <= (kidx_ff == 2'h2) ? 2'h0 : kidx_ff + 2'h1;
          sidx_ff <= (kidx_ff == 2'h2) ? sidx_ff + 3'h1 : sidx_ff;
          if (last) begin
            st_ff <= arc_pkg::SCAN_IDLE;
          end
        end
        default: st_ff <= arc_pkg::SCAN_IDLE;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv_st_ff <= 6'h00;
      pv_tr_ff <= 6'h00;
      pv_bk_ff <= 6'h00;
      ev_valid_ff <= 1'b0;
      ev_code_ff <= 6'h00;
      ev_time_ff <= 32'h0000_0000;
    end else begin
      if (chg && kidx_ff == 2'h0) pv_st_ff[sidx_ff] <= cur_bit;
      if (chg && kidx_ff == 2'h1) pv_tr_ff[sidx_ff] <= cur_bit;
      if (chg && kidx_ff == 2'h2) pv_bk_ff[sidx_ff] <= cur_bit;
      ev_valid_ff <= chg & (cur_bit ? ctrl_ff[`CTRL_MON] : ctrl_ff[`CTRL_MOFF]);
      ev_code_ff <= {sidx_ff, kidx_ff, cur_bit};
      ev_time_ff <= time_ff;
    end
  end
  // a clear that meets an event leaves a count of one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_st_ff <= 16'h0000;
      cnt_tr_ff <= 16'h0000;
      cnt_bk_ff <= 16'h0000;
    end else begin
      cnt_st_ff <= (cnt_clr ? 16'h0000 : cnt_st_ff) + {15'h0000, on_ev & (kidx_ff == 2'h0)};
      cnt_tr_ff <= (cnt_clr ? 16'h0000 : cnt_tr_ff) + {15'h0000, on_ev & (kidx_ff == 2'h1)};
      cnt_bk_ff <= (cnt_clr ? 16'h0000 : cnt_bk_ff) + {15'h0000, on_ev & (kidx_ff == 2'h2)};
    end
  end

  // operation log: ring of the newest twelve on-event records
  logic [31:0] lg_time [`LOG_DEPTH];
  logic [7:0] lg_info [`LOG_DEPTH];
  logic [31:0] lg_mag [`LOG_DEPTH];
  logic [15:0] lg_rem [`LOG_DEPTH];
  logic [3:0] wr_ff, lcnt_ff;
  wire logic [15:0] mag = (sidx_ff == 3'h5) ? residual_mag : phase_mag;
  wire logic [15:0] pkp = (sidx_ff == 3'h5) ? pkp_ff[31:16] : pkp_ff[15:0];
  wire logic [23:0] quot = (pkp == 16'h0000) ? 24'hFFFFFF : {mag, 8'h00} / {8'h00, pkp};
  wire logic [15:0] ratio = (quot[23:16] != 8'h00) ? 16'hFFFF : quot[15:0];
  wire logic [4:0] rd_base = {1'b0, wr_ff} + 5'h0B - {1'b0, lsel_ff};
  wire logic [3:0] rd_idx = (rd_base >= 5'h0C) ? 4'(rd_base - 5'h0C) : rd_base[3:0];
  always_ff @(posedge pclk) begin
    if (on_ev) begin
      lg_time[wr_ff] <= time_ff;
      lg_info[wr_ff] <= {scfg_ff[14:12], sidx_ff, kidx_ff};
      lg_mag[wr_ff] <= {mag, ratio};
      lg_rem[wr_ff] <= remain_v[sidx_ff];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ff <= 4'h0;
      lcnt_ff <= 4'h0;
    end else if (on_ev) begin
      wr_ff <= (wr_ff == 4'hB) ? 4'h0 : wr_ff + 4'h1;
      lcnt_ff <= (lcnt_ff == 4'hC) ? lcnt_ff : lcnt_ff + 4'h1;
    end
  end

  wire logic [31:0] status = {uf_ff, sf_ff, blk_v, trip_v, start_v, bi_ff, prs_ff, lit_ff};
  always_comb begin
    case (paddr)
      `A_CTRL: rd_data = ctrl_ff;
      `A_ZLIGHT: rd_data = zl_ff;
      `A_ZCURR: rd_data = zc_ff;
      `A_SCFG: rd_data = scfg_ff;
      `A_DLY: rd_data = dly_ff;
      `A_PKP: rd_data = pkp_ff;
      `A_STAT: rd_data = status;
      `A_CNT_ST: rd_data = {cnt_tr_ff, cnt_st_ff};
      `A_CNT_BK: rd_data = {16'h0000, cnt_bk_ff};
      `A_TIME: rd_data = time_ff;
      `A_LSEL: rd_data = {28'h0000000, lsel_ff};
      `A_LTIME: rd_data = lg_time[rd_idx];
      `A_LINFO: rd_data = {24'h000000, lg_info[rd_idx]};
      `A_LMAG: rd_data = lg_mag[rd_idx];
      `A_LREM: rd_data = {16'h0000, lg_rem[rd_idx]};
      `A_LCNT: rd_data = {28'h0000000, lcnt_ff};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign light_out = lit_ff;
  assign pressure_out = prs_ff;
  assign arc_bi_out = bi_ff;
  assign phase_start = start_v[4];
  assign residual_start = start_v[5];
  assign phase_blocked = blk_v[4];
  assign residual_blocked = blk_v[5];
  assign zone_trip = trip_v[3:0];
  assign zone_blocked = blk_v[3:0];
  assign sensor_fault = sf_ff;
  assign unit_fault = uf_ff;
  assign ev_valid = ev_valid_ff;
  assign ev_code = ev_code_ff;
  assign ev_time = ev_time_ff;

  property p_zone_off;
    @(posedge pclk) disable iff (!presetn) (tick && !ctrl_ff[0]) |=> !zone_trip[0];
  endproperty
  a_zone_off: assert property (p_zone_off) else $error("disabled zone tripped");
  property p_light_pin;
    @(posedge pclk) disable iff (!presetn) ##3 (light_out == $past(light_raw, 3));
  endproperty
  a_light_pin: assert property (p_light_pin) else $error("light output lags pin by other than three cycles");
  property p_tp_ignore;
    @(posedge pclk) disable iff (!presetn) (ctrl_ff[`CTRL_TPI] && $rose(bi_s)) |=> !arc_bi_out [*8];
  endproperty
  a_tp_ignore: assert property (p_tp_ignore) else $error("test pulse reached binary input output");
  property p_unit_fault;
    @(posedge pclk) disable iff (!presetn) ##1 (unit_fault == ($past(unit_s) != $past(scfg_ff[11:8])));
  endproperty
  a_unit_fault: assert property (p_unit_fault) else $error("unit fault does not follow count mismatch");
  property p_cnt_clr;
    @(posedge pclk) disable iff (!presetn) cnt_clr |=> (cnt_st_ff <= 16'h0001 && cnt_bk_ff <= 16'h0001);
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter reset ignored");
  property p_ev_scan;
    @(posedge pclk) disable iff (!presetn) ev_valid |-> $past(st_ff == arc_pkg::SCAN_RUN);
  endproperty
  a_ev_scan: assert property (p_ev_scan) else $error("event outside a scan");
  property p_log_cnt;
    @(posedge pclk) disable iff (!presetn) on_ev |=> (lcnt_ff == (($past(lcnt_ff) == 4'hC) ? 4'hC : $past(lcnt_ff) + 4'h1));
  endproperty
  a_log_cnt: assert property (p_log_cnt) else $error("log entry count wrong");
  property p_trip_block;
    @(posedge pclk) disable iff (!presetn) (tick && zone_pick[0] && zone_block[0]) |=> (zone_blocked[0] && !zone_trip[0]);
  endproperty
  a_trip_block: assert property (p_trip_block) else $error("blocked zone tripped");
endmodule : arc_fault_zone_protection
`default_nettype wire

// ===== arc_sensor_model.sv
// behavioural model of the arc sensor channels and current comparators
`timescale 1ns/1ns
`default_nettype none
module arc_sensor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] light_cmd,
  input wire logic [3:0] press_cmd,
  input wire logic bi_cmd,
  input wire logic pulse_en,
  input wire logic [7:0] fitted,
  input wire logic [3:0] units,
  input wire logic ph_cmd,
  input wire logic res_cmd,
  output logic [3:0] light_raw,
  output logic [3:0] pressure_raw,
  output logic arc_card_binary_input,
  output logic [7:0] sens_det_raw,
  output logic [3:0] unit_det_raw,
  output logic phase_over,
  output logic residual_over,
  output logic [15:0] phase_mag,
  output logic [15:0] residual_mag
);
  logic [8:0] tp_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tp_cnt_ff <= 9'h000;
    end else begin
      tp_cnt_ff <= tp_cnt_ff + 9'h001;
    end
  end
  assign light_raw = light_cmd;
  assign pressure_raw = press_cmd;
  // wiring test pulse: 64 cycles high in every 512
  assign arc_card_binary_input = bi_cmd | (pulse_en & (tp_cnt_ff < 9'h040));
  assign sens_det_raw = fitted;
  assign unit_det_raw = units;
  assign phase_over = ph_cmd;
  assign residual_over = res_cmd;
  assign phase_mag = ph_cmd ? 16'h0300 : 16'h0080;
  assign residual_mag = res_cmd ? 16'h0300 : 16'h0080;
endmodule : arc_sensor_model
`default_nettype wire

// ===== arc_fault_zone_protection_tb_top.sv
// self-checking testbench of the arc fault zone protection block
`timescale 1ns/1ns
`default_nettype none
module arc_fault_zone_protection_tb_top;
  localparam int C = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, sens_det_raw, fitted;
  logic [31:0] pwdata, prdata, q, ev_time;
  logic [3:0] light_raw, pressure_raw, unit_det_raw, zone_block, light_out, pressure_out;
  logic [3:0] zone_trip, zone_blocked, sensor_fault, light_cmd, press_cmd, units;
  logic arc_card_binary_input, phase_over, residual_over, phase_block, residual_block, arc_bi_out;
  logic phase_start, residual_start, phase_blocked, residual_blocked, unit_fault, ev_valid;
  logic bi_cmd, pulse_en, ph_cmd, res_cmd;
  logic [15:0] phase_mag, residual_mag;
  logic [5:0] ev_code, last_code;
  logic [31:0] last_time;
  int bad_count, compares, ev_n, bi_n, snap;
  arc_fault_zone_protection #(.CYCLE_CLKS(C), .MS_CLKS(10)) i_arc_fault_zone_protection (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .light_raw, .pressure_raw, .arc_card_binary_input, .sens_det_raw, .unit_det_raw,
    .phase_over, .residual_over, .phase_block, .residual_block, .zone_block, .phase_mag,
    .residual_mag, .light_out, .pressure_out, .arc_bi_out, .phase_start, .residual_start,
    .phase_blocked, .residual_blocked, .zone_trip, .zone_blocked, .sensor_fault,
    .unit_fault, .ev_valid, .ev_code, .ev_time);
  arc_sensor_model i_arc_sensor_model (
    .pclk, .presetn, .light_cmd, .press_cmd, .bi_cmd, .pulse_en, .fitted, .units, .ph_cmd,
    .res_cmd, .light_raw, .pressure_raw, .arc_card_binary_input, .sens_det_raw,
    .unit_det_raw, .phase_over, .residual_over, .phase_mag, .residual_mag);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (ev_valid === 1'b1) begin
      ev_n <= ev_n + 1;
      last_code <= ev_code;
      last_time <= ev_time;
    end
    if (arc_bi_out === 1'b1) bi_n <= bi_n + 1;
  end
  task results;
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    results();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, zone_block} = '0;
    {phase_block, residual_block, light_cmd, press_cmd, bi_cmd, pulse_en} = '0;
    {fitted, units, ph_cmd, res_cmd} = '0;
    wt(6);
    presetn <= 1'b1;
    wt(2);
    rd(8'h00, 32'h0000_0020);
    rd(8'h10, 32'h000C_0000);
    rd(8'h14, 32'h0100_0100);
    rd(8'h3C, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(32'(e), 32'h1);
    light_cmd <= 4'hA;
    press_cmd <= 4'h5;
    bi_cmd <= 1'b1;
    fitted <= 8'h02;
    units <= 4'h1;
    wt(8);
    chk(32'(light_out), 32'hA);
    chk(32'(pressure_out), 32'h5);
    chk(32'(arc_bi_out), 32'h1);
    chk(32'({sensor_fault, unit_fault}), 32'h03);
    apb(1'b1, 8'h0C, 32'h0000_0102);
    wt(4);
    chk(32'({sensor_fault, unit_fault}), 32'h00);
    {light_cmd, press_cmd, bi_cmd} <= '0;
    apb(1'b1, 8'h10, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0001_0001);
    apb(1'b1, 8'h00, 32'h0000_0061);
    wt(3 * C);
    chk(32'(zone_trip), 32'h0);
    snap = ev_n;
    light_cmd <= 4'h1;
    wt(3 * C);
    chk(32'(zone_trip), 32'h1);
    chk(ev_n - snap, 2);
    chk(32'(last_code), 32'h03);
    rd(8'h18, 32'h0000_8201);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk(q, last_time);
    rd(8'h30, 32'h0000_0001);
    light_cmd <= 4'h0;
    press_cmd <= 4'h1;
    wt(3 * C);
    chk(32'(zone_trip), 32'h1);
    apb(1'b1, 8'h00, 32'h0000_0060);
    wt(3 * C);
    chk(32'(zone_trip), 32'h0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0061);
    wt(3 * C);
    chk(32'(zone_trip), 32'h0);
    ph_cmd <= 1'b1;
    wt(3 * C);
    chk(32'({phase_start, zone_trip}), 32'h11);
    phase_block <= 1'b1;
    wt(3 * C);
    chk(32'({phase_blocked, phase_start}), 32'h2);
    phase_block <= 1'b0;
    wt(3 * C);
    zone_block <= 4'h1;
    wt(3 * C);
    chk(32'({zone_trip, zone_blocked}), 32'h01);
    rd(8'h1C, 32'h0005_0005);
    rd(8'h20, 32'h0000_0002);
    rd(8'h3C, 32'h0000_000C);
    apb(1'b1, 8'h00, 32'h0000_0161);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    res_cmd <= 1'b1;
    residual_block <= 1'b1;
    wt(3 * C);
    chk(32'({residual_blocked, residual_start}), 32'h2);
    residual_block <= 1'b0;
    wt(3 * C);
    chk(32'({residual_blocked, residual_start}), 32'h1);
    zone_block <= 4'h0;
    apb(1'b1, 8'h00, 32'h0000_0010);
    pulse_en <= 1'b1;
    snap = bi_n;
    wt(1200);
    chk(bi_n - snap, 0);
    results();
  end
endmodule : arc_fault_zone_protection_tb_top
`default_nettype wire
